//--- lram_defs.vh
/*
 Constants for the link resource allocation manager: register offsets,
 field positions, reset values, state and result codes, timing counts.
 Assumes a 100 MHz system clock and a 1 ms management tick.
*/
`ifndef LRAM_DEFS_VH
`define LRAM_DEFS_VH

`define LRAM_A_CTRL 8'h00
`define LRAM_A_CFG 8'h04
`define LRAM_A_PC 8'h08
`define LRAM_A_TMR 8'h0C
`define LRAM_A_PRE 8'h10
`define LRAM_A_STAT 8'h14
`define LRAM_A_TERM 8'h18

`define LRAM_F_EN 16
`define LRAM_F_MIN 4
`define LRAM_F_RPC 16
`define LRAM_F_T17 16

`define LRAM_RST_CFG 32'h0000_0012
`define LRAM_RST_PC 32'h0002_0001
`define LRAM_RST_PRE 32'h0403_0201

`define LRAM_S_INACT 3'h0
`define LRAM_S_WACK 3'h1
`define LRAM_S_ALIGN 3'h2
`define LRAM_S_TEST 3'h3
`define LRAM_S_ACT 3'h4
`define LRAM_S_RETRY 3'h5

`define LRAM_ACK_OK 2'h0
`define LRAM_ACK_ALT 2'h1
`define LRAM_ACK_NOALT 2'h2

`define LRAM_CLK_NS 10
`define LRAM_TICK_NS 1000000
`define LRAM_T7_MS 1000
`define LRAM_T17_MS 1000
`define LRAM_TICK_MS 1

`endif

//--- lram_ctrl.v
/*
 Link resource allocation manager for one signalling point and one link set:
 restores, activates and deactivates links, allocates terminals and data
 links, and runs the connection order / acknowledgement exchange.
 Assumes every input comes from logic on clk, at most one event per cycle.
*/
`timescale 1ns/100ps
`include "lram_defs.vh"

module lram_ctrl #(
	parameter NL       = 4,
	parameter LW       = 2,
	parameter NT       = 4,
	parameter TW       = 2,
	parameter TICK_DIV = `LRAM_TICK_NS / `LRAM_CLK_NS
) (
	input  wire          clk,
	input  wire          reset,
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [7:0]    wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	input  wire          link_fail_vld,
	input  wire [LW-1:0] link_fail_idx,
	input  wire          align_ok,
	input  wire          align_fail,
	input  wire          test_ok,
	input  wire          test_fail,
	input  wire [LW-1:0] res_link,
	input  wire [NL-1:0] traffic,
	output reg           att_vld,
	output reg  [LW-1:0] att_link,
	output reg  [TW-1:0] att_term,
	output reg  [7:0]    att_dl,
	output reg           test_go,
	output reg  [LW-1:0] test_link,
	output reg           det_vld,
	output reg  [TW-1:0] det_term,
	input  wire          dl_avail,
	input  wire [7:0]    dl_free_id,
	output reg           dl_take,
	output reg  [7:0]    dl_take_id,
	output reg           dl_rel,
	output reg  [7:0]    dl_rel_id,
	output reg           ord_vld,
	output reg  [13:0]   ord_dpc,
	output reg  [13:0]   ord_opc,
	output reg  [LW-1:0] ord_link,
	output reg  [7:0]    ord_dl,
	output reg           ack_vld,
	output reg  [LW-1:0] ack_link,
	output reg  [1:0]    ack_res,
	input  wire          rx_ord_vld,
	input  wire [13:0]   rx_ord_opc,
	input  wire [LW-1:0] rx_ord_link,
	input  wire [7:0]    rx_ord_dl,
	input  wire          rx_ack_vld,
	input  wire [LW-1:0] rx_ack_link,
	input  wire [1:0]    rx_ack_res,
	input  wire          loan_req,
	output reg           loan_gnt,
	output reg  [TW-1:0] loan_term,
	input  wire          loan_ret,
	input  wire [TW-1:0] loan_ret_term
);

	reg [2:0]    st_r  [0:NL-1];
	reg [TW-1:0] trm_r [0:NL-1];
	reg [7:0]    dl_r  [0:NL-1];
	reg [15:0]   tmr_r [0:NL-1];
	reg [NL-1:0] rst_r, trep_r, man_r, mreq_r;
	reg [NT-1:0] loan_r;
	reg [LW-1:0] ptr_r;
	reg [31:0]   cfg_r, pc_r, tm_r, pre_r;
	reg [31:0]   div_r;
	reg          tick_r;

	wire [3:0]  tgt = cfg_r[3:0];
	wire [3:0]  tmin = cfg_r[7:4];
	wire [15:0] t7 = tm_r[15:0];
	wire [15:0] t17 = tm_r[31:16];
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
		{8{wb_sel_i[0]}}};
	wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	integer i, k, j, n;
	reg [NT-1:0] tused;
	reg [3:0]    acnt, lcnt;
	reg          any_act, inflight, rep_busy, tf_v, ts_v, cand_v, dea_v, exp_v, dl_clash;
	reg [TW-1:0] tf, ts;
	reg [LW-1:0] ts_lk, cand, dea, exp_l, mlk;
	reg [23:0]   stv;

	always @* begin
		tused = loan_r;
		j = 0;
		acnt = 4'h0;
		lcnt = 4'h0;
		inflight = 1'b0;
		rep_busy = 1'b0;
		stv = 24'h0;
		dea_v = 1'b0;
		dea = {LW{1'b0}};
		exp_v = 1'b0;
		exp_l = {LW{1'b0}};
		mlk = {LW{1'b0}};
		dl_clash = 1'b0;
		for (i = 0; i < NL; i = i + 1) begin
			stv[3*i +: 3] = st_r[i];
			if (st_r[i] != `LRAM_S_INACT)
				tused[trm_r[i]] = 1'b1;
			if (st_r[i] != `LRAM_S_INACT && dl_r[i] == rx_ord_dl && i != rx_ord_link)
				dl_clash = 1'b1;
			if (st_r[i] == `LRAM_S_ACT) begin
				acnt = acnt + 4'h1;
				dea = i[LW-1:0];
			end
			if (st_r[i] == `LRAM_S_WACK || st_r[i] == `LRAM_S_ALIGN || st_r[i] == `LRAM_S_TEST) begin
				if (rst_r[i])
					rep_busy = 1'b1;
				else
					inflight = 1'b1;
			end
			if (!exp_v && tmr_r[i] == 16'h0 &&
				(st_r[i] == `LRAM_S_WACK || st_r[i] == `LRAM_S_RETRY)) begin
				exp_v = 1'b1;
				exp_l = i[LW-1:0];
			end
		end
		for (i = NL - 1; i >= 0; i = i - 1)
			if (mreq_r[i])
				mlk = i[LW-1:0];
		any_act = (acnt != 4'h0);
		// Lowest priority is the highest index; a busy one blocks the trim
		if (acnt > tgt && !traffic[dea])
			dea_v = 1'b1;
		tf_v = 1'b0;
		tf = {TW{1'b0}};
		for (i = NT - 1; i >= 0; i = i - 1) begin
			if (loan_r[i])
				lcnt = lcnt + 4'h1;
			if (!tused[i]) begin
				tf_v = 1'b1;
				tf = i[TW-1:0];
			end
		end
		ts_v = 1'b0;
		ts = {TW{1'b0}};
		ts_lk = {LW{1'b0}};
		for (i = NL - 1; i >= 0; i = i - 1)
			if (st_r[i] == `LRAM_S_RETRY) begin
				ts_v = 1'b1;
				ts = trm_r[i];
				ts_lk = i[LW-1:0];
			end
		cand_v = 1'b0;
		cand = {LW{1'b0}};
		for (k = NL - 1; k >= 0; k = k - 1) begin
			j = (ptr_r + k) % NL;
			if (st_r[j] == `LRAM_S_INACT && !man_r[j]) begin
				cand_v = 1'b1;
				cand = j[LW-1:0];
			end
		end
	end

	wire          t_ok = tf_v | ts_v;
	wire [TW-1:0] t_pick = tf_v ? tf : ts;
	wire [LW-1:0] r = res_link;
	wire          r_fail = (align_fail && st_r[r] == `LRAM_S_ALIGN) ||
		(test_fail && st_r[r] == `LRAM_S_TEST);
	wire [LW-1:0] ol = rx_ord_link;
	wire [LW-1:0] al = rx_ack_link;
	wire          act_go = cfg_r[`LRAM_F_EN] && acnt < tgt && cand_v && !inflight && !rep_busy;
	wire [LW-1:0] nxt = (cand == NL - 1) ? {LW{1'b0}} : cand + 1'b1;

	always @(posedge clk) begin
		if (reset) begin
			div_r <= 32'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == TICK_DIV - 1);
			div_r <= (div_r == TICK_DIV - 1) ? 32'h0 : div_r + 32'h1;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			cfg_r <= `LRAM_RST_CFG;
			pc_r <= `LRAM_RST_PC;
			tm_r <= ((`LRAM_T17_MS / `LRAM_TICK_MS) << 16) | (`LRAM_T7_MS / `LRAM_TICK_MS);
			pre_r <= `LRAM_RST_PRE;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			case (wb_adr_i)
			`LRAM_A_CTRL: wb_dat_o <= {15'h0, cfg_r[`LRAM_F_EN], 8'h0, 8'h0 | man_r};
			`LRAM_A_CFG: wb_dat_o <= cfg_r;
			`LRAM_A_PC: wb_dat_o <= pc_r;
			`LRAM_A_TMR: wb_dat_o <= tm_r;
			`LRAM_A_PRE: wb_dat_o <= pre_r;
			`LRAM_A_STAT: wb_dat_o <= {4'h0, acnt, stv};
			`LRAM_A_TERM: wb_dat_o <= {16'h0, 8'h0 | loan_r, 8'h0 | tused};
			default: wb_dat_o <= 32'h0;
			endcase
			if (wr && wb_adr_i == `LRAM_A_CFG)
				cfg_r <= (cfg_r & ~wmask) | (wb_dat_i & wmask);
			if (wr && wb_adr_i == `LRAM_A_CTRL && wb_sel_i[2])
				cfg_r[`LRAM_F_EN] <= wb_dat_i[`LRAM_F_EN];
			if (wr && wb_adr_i == `LRAM_A_PC)
				pc_r <= (pc_r & ~wmask) | (wb_dat_i & wmask);
			if (wr && wb_adr_i == `LRAM_A_TMR)
				tm_r <= (tm_r & ~wmask) | (wb_dat_i & wmask);
			if (wr && wb_adr_i == `LRAM_A_PRE)
				pre_r <= (pre_r & ~wmask) | (wb_dat_i & wmask);
		end
	end

	wire [NL-1:0] ctl_dea = (wr && wb_adr_i == `LRAM_A_CTRL && wb_sel_i[0]) ? wb_dat_i[NL-1:0] : {NL{1'b0}};
	wire [NL-1:0] ctl_clr = (wr && wb_adr_i == `LRAM_A_CTRL && wb_sel_i[1]) ? wb_dat_i[8 +: NL] : {NL{1'b0}};

	always @(posedge clk) begin
		att_vld <= 1'b0;
		test_go <= 1'b0;
		det_vld <= 1'b0;
		dl_take <= 1'b0;
		dl_rel <= 1'b0;
		ord_vld <= 1'b0;
		ack_vld <= 1'b0;
		loan_gnt <= 1'b0;
		if (reset) begin
			for (n = 0; n < NL; n = n + 1) begin
				st_r[n] <= `LRAM_S_INACT;
				trm_r[n] <= {TW{1'b0}};
				dl_r[n] <= 8'h0;
				tmr_r[n] <= 16'h0;
			end
			rst_r <= {NL{1'b0}};
			trep_r <= {NL{1'b0}};
			man_r <= {NL{1'b0}};
			mreq_r <= {NL{1'b0}};
			loan_r <= {NT{1'b0}};
			ptr_r <= {LW{1'b0}};
			att_link <= {LW{1'b0}};
			att_term <= {TW{1'b0}};
			att_dl <= 8'h0;
			test_link <= {LW{1'b0}};
			det_term <= {TW{1'b0}};
			dl_take_id <= 8'h0;
			dl_rel_id <= 8'h0;
			ord_dpc <= 14'h0;
			ord_opc <= 14'h0;
			ord_link <= {LW{1'b0}};
			ord_dl <= 8'h0;
			ack_link <= {LW{1'b0}};
			ack_res <= 2'h0;
			loan_term <= {TW{1'b0}};
		end else begin
			for (n = 0; n < NL; n = n + 1)
				if (tick_r && tmr_r[n] != 16'h0)
					tmr_r[n] <= tmr_r[n] - 16'h1;
			man_r <= man_r & ~ctl_clr;
			ord_dpc <= pc_r[`LRAM_F_RPC +: 14];
			ord_opc <= pc_r[13:0];
			if (loan_ret)
				loan_r[loan_ret_term] <= 1'b0;
			if (rx_ord_vld) begin
				ack_link <= ol;
				if (st_r[ol] == `LRAM_S_INACT) begin
					ack_vld <= 1'b1;
					if (!t_ok)
						ack_res <= `LRAM_ACK_NOALT;
					else if (dl_clash)
						ack_res <= `LRAM_ACK_ALT;
					else begin
						ack_res <= `LRAM_ACK_OK;
						if (!tf_v) begin
							st_r[ts_lk] <= `LRAM_S_INACT;
							dl_rel <= 1'b1;
							dl_rel_id <= dl_r[ts_lk];
						end
						trm_r[ol] <= t_pick;
						dl_r[ol] <= rx_ord_dl;
						dl_take <= 1'b1;
						dl_take_id <= rx_ord_dl;
						att_vld <= 1'b1;
						att_link <= ol;
						att_term <= t_pick;
						att_dl <= rx_ord_dl;
						st_r[ol] <= `LRAM_S_ALIGN;
					end
				end else if (st_r[ol] == `LRAM_S_WACK && pc_r[13:0] < rx_ord_opc) begin
					// Far end has the higher code, so its data link wins
					ack_vld <= 1'b1;
					ack_res <= `LRAM_ACK_OK;
					dl_rel <= 1'b1;
					dl_rel_id <= dl_r[ol];
					dl_take <= 1'b1;
					dl_take_id <= rx_ord_dl;
					dl_r[ol] <= rx_ord_dl;
					att_vld <= 1'b1;
					att_link <= ol;
					att_term <= trm_r[ol];
					att_dl <= rx_ord_dl;
					st_r[ol] <= `LRAM_S_ALIGN;
				end
				// Other states: order is dropped
			end else if (rx_ack_vld && st_r[al] == `LRAM_S_WACK) begin
				if (rx_ack_res == `LRAM_ACK_OK) begin
					att_vld <= 1'b1;
					att_link <= al;
					att_term <= trm_r[al];
					att_dl <= dl_r[al];
					st_r[al] <= `LRAM_S_ALIGN;
				end else begin
					dl_rel <= 1'b1;
					dl_rel_id <= dl_r[al];
					if (rx_ack_res == `LRAM_ACK_ALT && dl_avail) begin
						dl_take <= 1'b1;
						dl_take_id <= dl_free_id;
						dl_r[al] <= dl_free_id;
						ord_vld <= 1'b1;
						ord_link <= al;
						ord_dl <= dl_free_id;
						tmr_r[al] <= t7;
					end else begin
						st_r[al] <= `LRAM_S_INACT;
						rst_r[al] <= 1'b0;
						ptr_r <= (al == NL - 1) ? {LW{1'b0}} : al + 1'b1;
					end
				end
			end else if (align_ok && st_r[r] == `LRAM_S_ALIGN) begin
				st_r[r] <= `LRAM_S_TEST;
				test_go <= 1'b1;
				test_link <= r;
			end else if (test_ok && st_r[r] == `LRAM_S_TEST) begin
				st_r[r] <= `LRAM_S_ACT;
				rst_r[r] <= 1'b0;
			end else if (r_fail) begin
				if (rst_r[r] && !trep_r[r] && dl_avail) begin
					dl_rel <= 1'b1;
					dl_rel_id <= dl_r[r];
					dl_take <= 1'b1;
					dl_take_id <= dl_free_id;
					dl_r[r] <= dl_free_id;
					ord_vld <= 1'b1;
					ord_link <= r;
					ord_dl <= dl_free_id;
					tmr_r[r] <= t7;
					st_r[r] <= `LRAM_S_WACK;
				end else if (rst_r[r] && !trep_r[r] && tf_v) begin
					trep_r[r] <= 1'b1;
					det_vld <= 1'b1;
					det_term <= trm_r[r];
					trm_r[r] <= tf;
					att_vld <= 1'b1;
					att_link <= r;
					att_term <= tf;
					att_dl <= dl_r[r];
					st_r[r] <= `LRAM_S_ALIGN;
				end else begin
					// Parked on its terminal; next link may now start
					st_r[r] <= `LRAM_S_RETRY;
					tmr_r[r] <= t17;
					rst_r[r] <= 1'b0;
					trep_r[r] <= 1'b0;
					ptr_r <= (r == NL - 1) ? {LW{1'b0}} : r + 1'b1;
				end
			end else if (link_fail_vld && (st_r[link_fail_idx] == `LRAM_S_ACT ||
				st_r[link_fail_idx] == `LRAM_S_TEST)) begin
				st_r[link_fail_idx] <= `LRAM_S_ALIGN;
				rst_r[link_fail_idx] <= 1'b1;
				trep_r[link_fail_idx] <= 1'b0;
				att_vld <= 1'b1;
				att_link <= link_fail_idx;
				att_term <= trm_r[link_fail_idx];
				att_dl <= dl_r[link_fail_idx];
			end else if (exp_v) begin
				if (st_r[exp_l] == `LRAM_S_WACK) begin
					ord_vld <= 1'b1;
					ord_link <= exp_l;
					ord_dl <= dl_r[exp_l];
					tmr_r[exp_l] <= t7;
				end else begin
					st_r[exp_l] <= `LRAM_S_ALIGN;
					att_vld <= 1'b1;
					att_link <= exp_l;
					att_term <= trm_r[exp_l];
					att_dl <= dl_r[exp_l];
				end
			end else if (mreq_r != {NL{1'b0}} || dea_v) begin
				if (mreq_r != {NL{1'b0}}) begin
					mreq_r[mlk] <= 1'b0;
					man_r[mlk] <= 1'b1;
				end
				if (mreq_r == {NL{1'b0}} || st_r[mlk] != `LRAM_S_INACT) begin
					st_r[mreq_r != {NL{1'b0}} ? mlk : dea] <= `LRAM_S_INACT;
					det_vld <= 1'b1;
					det_term <= trm_r[mreq_r != {NL{1'b0}} ? mlk : dea];
					dl_rel <= 1'b1;
					dl_rel_id <= dl_r[mreq_r != {NL{1'b0}} ? mlk : dea];
				end
			end else if (act_go) begin
				if (t_ok && (dl_avail || !any_act)) begin
					if (!tf_v) begin
						st_r[ts_lk] <= `LRAM_S_INACT;
						dl_rel <= 1'b1;
						dl_rel_id <= dl_r[ts_lk];
					end
					trm_r[cand] <= t_pick;
					// Predetermined list while the set has no active link
					dl_r[cand] <= any_act ? dl_free_id : pre_r[8 * cand +: 8];
					dl_take <= 1'b1;
					dl_take_id <= any_act ? dl_free_id : pre_r[8 * cand +: 8];
					ord_vld <= 1'b1;
					ord_link <= cand;
					ord_dl <= any_act ? dl_free_id : pre_r[8 * cand +: 8];
					tmr_r[cand] <= t7;
					st_r[cand] <= `LRAM_S_WACK;
				end else
					ptr_r <= nxt;
			end else if (loan_req && tf_v && (NT - lcnt - 1) >= tmin) begin
				loan_r[tf] <= 1'b1;
				loan_gnt <= 1'b1;
				loan_term <= tf;
			end
			// A new manual request beats the clear of one being served
			for (n = 0; n < NL; n = n + 1)
				if (ctl_dea[n])
					mreq_r[n] <= 1'b1;
		end
	end

endmodule // lram_ctrl

//--- lram_chk_asserts.sv
/*
 Port checks for lram_ctrl.
 Assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/100ps
`include "lram_defs.vh"
module lram_chk #(
	parameter LW = 2
) (
	input wire          clk,
	input wire          reset,
	input wire          wb_cyc_i,
	input wire          wb_stb_i,
	input wire          wb_ack_o,
	input wire          align_ok,
	input wire [LW-1:0] res_link,
	input wire          test_go,
	input wire [LW-1:0] test_link,
	input wire          dl_take,
	input wire [7:0]    dl_take_id,
	input wire          ord_vld,
	input wire [7:0]    ord_dl,
	input wire          att_vld,
	input wire [LW-1:0] att_link,
	input wire          ack_vld,
	input wire [LW-1:0] ack_link,
	input wire          rx_ord_vld,
	input wire [LW-1:0] rx_ord_link,
	input wire          rx_ack_vld,
	input wire [LW-1:0] rx_ack_link,
	input wire [1:0]    rx_ack_res,
	input wire          loan_req,
	input wire          loan_gnt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus access not answered");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	chk_test_after: assert property (test_go |-> $past(align_ok) && $past(res_link) == test_link)
		else $error("link test without alignment");
	chk_order_take: assert property (dl_take && ord_vld |-> ord_dl == dl_take_id)
		else $error("order names another data link");
	chk_ack_order: assert property (ack_vld |-> $past(rx_ord_vld) && ack_link == $past(rx_ord_link))
		else $error("acknowledgement without order");
	chk_loan_req: assert property (loan_gnt |-> $past(loan_req))
		else $error("terminal lent unasked");
	chk_ok_attach: assert property (rx_ack_vld && rx_ack_res == `LRAM_ACK_OK |=> att_vld && att_link == $past(rx_ack_link))
		else $error("no attach after good ack");
	chk_noalt_quiet: assert property (rx_ack_vld && rx_ack_res == `LRAM_ACK_NOALT |=> !att_vld && !ord_vld)
		else $error("activity after no-alternative ack");
endmodule // lram_chk

bind lram_ctrl lram_chk #(.LW(LW)) u_chk (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .align_ok(align_ok), .res_link(res_link),
	.test_go(test_go), .test_link(test_link), .dl_take(dl_take), .dl_take_id(dl_take_id),
	.ord_vld(ord_vld), .ord_dl(ord_dl), .att_vld(att_vld), .att_link(att_link),
	.ack_vld(ack_vld), .ack_link(ack_link), .rx_ord_vld(rx_ord_vld), .rx_ord_link(rx_ord_link),
	.rx_ack_vld(rx_ack_vld), .rx_ack_link(rx_ack_link), .rx_ack_res(rx_ack_res),
	.loan_req(loan_req), .loan_gnt(loan_gnt));

//--- lram_peer.sv
/*
 Remote link manager model: answers orders after a random delay, injects
 orders and acknowledgements when the bench asks. One request at a time.
*/
`timescale 1ns/100ps
module lram_peer #(
	parameter [13:0] OWN_PC = 14'h0002
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        ans_on,
	input  wire [1:0]  ans_res,
	input  wire [31:0] rnd,
	input  wire        ord_vld,
	input  wire [1:0]  ord_link,
	input  wire        inj_ord,
	input  wire        inj_ack,
	input  wire [1:0]  inj_link,
	input  wire [7:0]  inj_dl,
	output reg         rx_ord_vld,
	output reg  [13:0] rx_ord_opc,
	output reg  [1:0]  rx_ord_link,
	output reg  [7:0]  rx_ord_dl,
	output reg         rx_ack_vld,
	output reg  [1:0]  rx_ack_link,
	output reg  [1:0]  rx_ack_res
);
	reg       pend_r;
	reg [2:0] wait_r;
	reg [1:0] link_r;
	wire      ans_go = pend_r && wait_r == 3'h0;

	// Idle fields flip each cycle so stale data never looks valid
	always @(posedge clk) begin
		if (reset) begin
			{pend_r, wait_r, link_r, rx_ord_vld, rx_ack_vld} <= 8'h00;
			{rx_ord_opc, rx_ord_link, rx_ord_dl, rx_ack_link, rx_ack_res} <= 28'h0;
		end else begin
			rx_ord_vld <= inj_ord;
			rx_ack_vld <= ans_go || inj_ack;
			{rx_ord_opc, rx_ord_link, rx_ord_dl} <= inj_ord ? {OWN_PC, inj_link, inj_dl}
				: ~{rx_ord_opc, rx_ord_link, rx_ord_dl};
			{rx_ack_link, rx_ack_res} <= inj_ack ? {inj_link, ans_res}
				: ans_go ? {link_r, ans_res} : ~{rx_ack_link, rx_ack_res};
			// Silent while ans_on is low, so the sender must repeat
			if (ord_vld && ans_on) begin
				{pend_r, wait_r, link_r} <= {1'b1, rnd[2:0], ord_link};
			end else if (ans_go) begin
				pend_r <= 1'b0;
			end else if (pend_r) begin
				wait_r <= wait_r - 3'h1;
			end
		end
	end
endmodule // lram_peer

//--- lram_ctrl_tb.sv
/*
 Self-checking bench for lram_ctrl: registers, activation with resend,
 restoration, remote order, auto deactivation, terminal loan.
 Assumes lram_peer on the remote side and the bound checker.
*/
`timescale 1ns/100ps
`include "lram_defs.vh"
module lram_ctrl_tb;
	logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, link_fail_vld, align_ok, align_fail;
	logic        test_ok, loan_req, dl_avail, ans_on, inj_ord, inj_ack, seen;
	logic [7:0]  wb_adr_i, dl_free_id, inj_dl, fid;
	logic [3:0]  wb_sel_i, traffic;
	logic [31:0] wb_dat_i, rd;
	logic [1:0]  link_fail_idx, res_link, inj_link, ans_res;
	logic [31:0] xs = 32'hAC89_2818;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, att_vld, test_go, det_vld, dl_take, dl_rel, ord_vld, ack_vld;
	wire         loan_gnt, rx_ord_vld, rx_ack_vld;
	wire  [1:0]  att_link, test_link, ord_link, ack_link, ack_res, rx_ord_link, rx_ack_link;
	wire  [1:0]  rx_ack_res, loan_term;
	wire  [7:0]  att_dl, dl_take_id, dl_rel_id, ord_dl, rx_ord_dl;
	wire  [13:0] ord_dpc, ord_opc, rx_ord_opc;
	wire  [7:0]  ev = {loan_gnt, dl_rel, det_vld, ack_vld, dl_take, test_go, att_vld, ord_vld};
	int          mismatches, samples_checked, cyc, t0;
	int          st[4];

	lram_ctrl #(.TICK_DIV(4)) dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.link_fail_vld(link_fail_vld), .link_fail_idx(link_fail_idx), .align_ok(align_ok),
		.align_fail(align_fail), .test_ok(test_ok), .test_fail(1'b0), .res_link(res_link),
		.traffic(traffic), .att_vld(att_vld), .att_link(att_link), .att_term(), .att_dl(att_dl),
		.test_go(test_go), .test_link(test_link), .det_vld(det_vld), .det_term(),
		.dl_avail(dl_avail), .dl_free_id(dl_free_id), .dl_take(dl_take), .dl_take_id(dl_take_id),
		.dl_rel(dl_rel), .dl_rel_id(dl_rel_id), .ord_vld(ord_vld), .ord_dpc(ord_dpc),
		.ord_opc(ord_opc), .ord_link(ord_link), .ord_dl(ord_dl), .ack_vld(ack_vld),
		.ack_link(ack_link), .ack_res(ack_res), .rx_ord_vld(rx_ord_vld), .rx_ord_opc(rx_ord_opc),
		.rx_ord_link(rx_ord_link), .rx_ord_dl(rx_ord_dl), .rx_ack_vld(rx_ack_vld),
		.rx_ack_link(rx_ack_link), .rx_ack_res(rx_ack_res), .loan_req(loan_req),
		.loan_gnt(loan_gnt), .loan_term(loan_term), .loan_ret(1'b0), .loan_ret_term(2'b00));

	lram_peer peer (.clk(clk), .reset(reset), .ans_on(ans_on), .ans_res(ans_res), .rnd(xs),
		.ord_vld(ord_vld), .ord_link(ord_link), .inj_ord(inj_ord), .inj_ack(inj_ack),
		.inj_link(inj_link), .inj_dl(inj_dl), .rx_ord_vld(rx_ord_vld), .rx_ord_opc(rx_ord_opc),
		.rx_ord_link(rx_ord_link), .rx_ord_dl(rx_ord_dl), .rx_ack_vld(rx_ack_vld),
		.rx_ack_link(rx_ack_link), .rx_ack_res(rx_ack_res));

	function automatic logic [31:0] xorshift(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	always @(posedge clk) begin
		cyc <= cyc + 1;
		xs <= xorshift(xs);
	end

	task check(input string what, input logic [31:0] sv, input logic [31:0] ev_v);
		samples_checked++;
		if (sv !== ev_v) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, ev_v, sv);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task fail_out;
		mismatches++;
		end_of_test;
	endtask

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		do begin
			@(posedge clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (wb_ack_o !== 1'b1) fail_out;
		@(posedge clk);
	endtask

	task wait_ev(input int b);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ev[b] !== 1'b1 && i < 300);
		if (ev[b] !== 1'b1) fail_out;
	endtask

	// k: 0 align ok, 1 align fail, 2 test ok, 3 link fail, 4 loan, 5 order, 6 ack
	task pulse(input int k, input logic [1:0] l);
		{res_link, link_fail_idx, inj_link} <= {l, l, l};
		{align_ok, align_fail, test_ok, link_fail_vld, loan_req, inj_ord, inj_ack} <= 7'h40 >> k;
		@(posedge clk);
		{align_ok, align_fail, test_ok, link_fail_vld, loan_req, inj_ord, inj_ack} <= 7'h00;
	endtask

	task chk_stat;
		logic [31:0] e;
		int n;
		e = 32'h0;
		n = 0;
		for (int i = 0; i < 4; i++) begin
			e[3*i +: 3] = st[i][2:0];
			n += (st[i] == 4);
		end
		e[27:24] = n[3:0];
		wb(1'b0, `LRAM_A_STAT, 32'h0);
		check("link states", rd & 32'h0F00_0FFF, e);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 8'h00, 4'hF, 32'h0};
		{link_fail_vld, align_ok, align_fail, test_ok, loan_req, dl_avail} = 6'h00;
		{ans_on, inj_ord, inj_ack, link_fail_idx, res_link, inj_link, ans_res} = 11'h000;
		{traffic, dl_free_id, inj_dl} = 20'h0;
		mismatches = 0;
		samples_checked = 0;
		cyc = 0;
		st = '{default: 0};
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		wb(1'b0, `LRAM_A_CFG, 32'h0);
		check("cfg", rd, `LRAM_RST_CFG);
		wb(1'b0, `LRAM_A_PC, 32'h0);
		check("point codes", rd, `LRAM_RST_PC);
		wb(1'b0, `LRAM_A_PRE, 32'h0);
		check("preset", rd, `LRAM_RST_PRE);
		wb(1'b0, `LRAM_A_TMR, 32'h0);
		check("timers", rd, {16'(`LRAM_T17_MS), 16'(`LRAM_T7_MS)});
		wb(1'b0, 8'h1C, 32'h0);
		check("unmapped", rd, 32'h0);
		chk_stat;
		wb(1'b1, `LRAM_A_TMR, 32'h0002_0003);
		wb(1'b1, `LRAM_A_CFG, 32'h0000_0011);
		wb(1'b1, `LRAM_A_CTRL, 32'h0001_0000);
		wait_ev(0);
		t0 = cyc;
		check("order link", 32'(ord_link), 32'h0);
		check("order data link", 32'(ord_dl), 32'h01);
		check("order labels", {4'h0, ord_dpc, ord_opc}, {4'h0, 14'h0002, 14'h0001});
		wait_ev(0);
		check("resend gap", 32'(cyc - t0 >= 8 && cyc - t0 <= 17), 32'h1);
		ans_on <= 1'b1;
		wait_ev(1);
		check("attach", {att_link, att_dl}, {2'h0, 8'h01});
		pulse(0, 2'h0);
		wait_ev(2);
		check("test link", 32'(test_link), 32'h0);
		pulse(2, 2'h0);
		st[0] = 4;
		chk_stat;
		fid = xs[7:0] | 8'h80;
		{dl_avail, dl_free_id} <= {1'b1, fid};
		pulse(3, 2'h0);
		wait_ev(1);
		check("realign link", 32'(att_link), 32'h0);
		pulse(1, 2'h0);
		wait_ev(3);
		check("taken data link", 32'(dl_take_id), 32'(fid));
		wait_ev(1);
		check("order new link", 32'(ord_dl), 32'(fid));
		check("new link attached", 32'(att_dl), 32'(fid));
		dl_avail <= 1'b0;
		pulse(0, 2'h0);
		wait_ev(2);
		pulse(2, 2'h0);
		{traffic, inj_dl} <= {4'b0100, 8'h33};
		pulse(5, 2'h2);
		wait_ev(4);
		check("ack", {ack_link, ack_res}, {2'h2, `LRAM_ACK_OK});
		repeat (2) @(posedge clk);
		check("remote data link", 32'(att_dl), 32'h33);
		pulse(0, 2'h2);
		wait_ev(2);
		pulse(2, 2'h2);
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk);
			seen |= det_vld;
		end
		check("busy link kept", 32'(seen), 32'h0);
		traffic <= 4'h0;
		wait_ev(5);
		if (dl_rel !== 1'b1) wait_ev(6);
		check("released data link", 32'(dl_rel_id), 32'h33);
		chk_stat;
		ans_res <= `LRAM_ACK_NOALT;
		pulse(6, 2'h3);
		@(posedge clk);
		pulse(4, 2'h0);
		wait_ev(7);
		check("lent terminal", 32'(loan_term), 32'h1);
		end_of_test;
	end
endmodule // lram_ctrl_tb
